// file: lclf_fault_resp.sv
`timescale 1ns/1ps
// Operation
// - A 4-bit response mode field at bits 18 to 15, reset to zero, picks the fault action.
// - Modes 0 and 1 latch the fault, assert the fault pin and tristate the gate drive.
// - Mode 2 latches the fault, asserts the fault pin and turns on all high-side switches.
// - Mode 3 latches the fault, asserts the fault pin and turns on all low-side switches.
// - Modes 4 and 5 self-clear after the wait, and latch tristated once retries run out.
// - Mode 6 self-clears after the wait, and latches in high-side brake once retries run out.
// - Mode 7 self-clears after the wait, and latches in low-side brake once retries run out.
// - Mode 8 only asserts the fault pin and leaves the gate drive alone.
// - Modes 9 to 12 disable detection with no fault and no pin assertion.
// - The filter field at bits 14 to 11 selects 0.2 ms to 1000 ms for codes 2 to 15.
// - The 4-bit wait field selects 300 ms, 500 ms, then 1 s to 14 s in one-second steps.
// - The 4-bit threshold code selects 0.125 A up to 8.0 A.
module lclf_fault_resp import lclf_pkg::*; #(
    parameter int unsigned CYC_PER_US = CYC_PER_US_DEF
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [15:0] phase_current_ma,
    output lclf_gate_t gate_cmd,
    output logic fault_pin_n,
    output logic irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    logic [31:0] cfg_reg;
    logic [NSTAT-1:0] status_reg;
    logic [NSTAT-1:0] status_next;
    logic [NSTAT-1:0] mask_reg;
    logic [3:0] max_recovery_attempts;
    logic [3:0] attempts_reg;
    logic [31:0] retry_cnt_reg;
    logic [31:0] readdata_reg;
    logic wait_reg;
    logic irq_reg;
    logic pin_n_reg;
    lclf_gate_t gate_reg;
    lclf_gate_t gate_next;
    lclf_state_t state_reg;
    lclf_state_t state_next;
    logic [3:0] mode;
    logic [3:0] overcurrent_lock_filter_time;
    logic [3:0] stall_recovery_wait;
    logic [3:0] thr_code;
    logic over_thr;
    logic trip;
    logic [31:0] deg_cycles;
    logic [31:0] retry_cycles;
    logic acc_done;
    logic wr_cfg;
    logic wr_ctrl;
    logic rd_status;
    logic sw_clear;
    lclf_act_t act;
    logic exhausted;

    // Mode field to action class; codes above 12 fall into the off class
    function automatic lclf_act_t mode_act(input logic [3:0] m);
        case (m)
            4'h0, 4'h1, 4'h2, 4'h3: mode_act = ACT_LATCH;
            4'h4, 4'h5, 4'h6, 4'h7: mode_act = ACT_RETRY;
            4'h8: mode_act = ACT_REPORT;
            default: mode_act = ACT_OFF;
        endcase
    endfunction

    // Gate drive applied while a fault is active in the given mode
    function automatic lclf_gate_t mode_drive(input logic [3:0] m);
        lclf_gate_t g;
        g = '{hiz: 1'b0, hs_on: 1'b0, ls_on: 1'b0};
        case (m)
            4'h2, 4'h6: g.hs_on = 1'b1;
            4'h3, 4'h7: g.ls_on = 1'b1;
            4'h0, 4'h1, 4'h4, 4'h5: g.hiz = 1'b1;
            default: g.hiz = 1'b0;
        endcase
        return g;
    endfunction

    // Field extraction
    assign mode = cfg_reg[MODE_LSB +: FLD_W];
    assign overcurrent_lock_filter_time = cfg_reg[DEG_LSB +: FLD_W];
    assign stall_recovery_wait = cfg_reg[RETRY_LSB +: FLD_W];
    assign thr_code = cfg_reg[THR_LSB +: FLD_W];
    assign act = mode_act(mode);
    assign exhausted = attempts_reg >= max_recovery_attempts;

    // Threshold compare and time tables scaled to clock cycles
    assign over_thr = phase_current_ma > thr_ma(thr_code);
    assign deg_cycles = 32'(deg_time_us(overcurrent_lock_filter_time) * CYC_PER_US);
    assign retry_cycles = 32'(retry_time_ms(stall_recovery_wait) * 32'd1000 * CYC_PER_US);

    lclf_deglitch u_deglitch (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .cond(over_thr && act != ACT_OFF),
        .limit(deg_cycles),
        .trip(trip)
    );

    // Bus strobes; an access completes in the cycle waitrequest is low
    assign acc_done = (avs_read || avs_write) && !wait_reg;
    assign wr_cfg = acc_done && avs_write && avs_address == OFS_CFG;
    assign wr_ctrl = acc_done && avs_write && avs_address == OFS_CTRL;
    assign rd_status = acc_done && avs_read && avs_address == OFS_STATUS;
    assign sw_clear = wr_ctrl && avs_writedata[CLR_BIT];

    // Response state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (trip) begin
                    case (act)
                        ACT_LATCH: state_next = ST_LATCHED;
                        ACT_RETRY: state_next = exhausted ? ST_LATCHED : ST_WAIT;
                        ACT_REPORT: state_next = ST_REPORT;
                        default: state_next = ST_IDLE;
                    endcase
                end
            end
            ST_WAIT: begin
                if (retry_cnt_reg == 32'h0) begin
                    state_next = ST_IDLE;
                end
            end
            ST_LATCHED: begin
                if (sw_clear) begin
                    state_next = ST_IDLE;
                end
            end
            ST_REPORT: begin
                if (!trip) begin
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // Gate drive follows the fault state; report and idle leave it alone
    always_comb begin
        case (state_next)
            ST_WAIT, ST_LATCHED: gate_next = mode_drive(mode);
            default: gate_next = '{hiz: 1'b0, hs_on: 1'b0, ls_on: 1'b0};
        endcase
    end

    // State and registered pin outputs, aligned to the same edge
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg <= ST_IDLE;
            gate_reg <= '{hiz: 1'b0, hs_on: 1'b0, ls_on: 1'b0};
            pin_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            gate_reg <= gate_next;
            pin_n_reg <= (state_next == ST_IDLE);
        end
    end

    // Recovery timer, loaded on entry to the wait
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            retry_cnt_reg <= 32'h0;
        end else if (state_reg != ST_WAIT && state_next == ST_WAIT) begin
            retry_cnt_reg <= (retry_cycles > 32'h1) ? retry_cycles - 32'h1 : 32'h0;
        end else if (state_reg == ST_WAIT && retry_cnt_reg != 32'h0) begin
            retry_cnt_reg <= retry_cnt_reg - 32'h1;
        end
    end

    // Attempt counter; kept across recoveries so repeated stalls run out
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            attempts_reg <= 4'h0;
        end else if (sw_clear) begin
            attempts_reg <= 4'h0;
        end else if (state_reg == ST_IDLE && state_next == ST_WAIT) begin
            attempts_reg <= attempts_reg + 4'h1;
        end
    end

    // Configuration, mask and control registers
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cfg_reg <= CFG_RST;
            mask_reg <= MASK_RST;
            max_recovery_attempts <= ATT_RST;
        end else begin
            if (wr_cfg) begin
                cfg_reg <= avs_writedata;
            end
            if (acc_done && avs_write && avs_address == OFS_MASK) begin
                mask_reg <= avs_writedata[NSTAT-1:0];
            end
            if (wr_ctrl) begin
                max_recovery_attempts <= avs_writedata[ATT_LSB +: 4];
            end
        end
    end

    // Sticky events; a new event wins over the read that clears
    always_comb begin
        status_next = rd_status ? (status_reg & ~readdata_reg[NSTAT-1:0]) : status_reg; // Unread kept
        if (state_reg == ST_IDLE && state_next != ST_IDLE) begin
            status_next[ST_TRIP] = 1'b1;
        end
        if (state_reg != ST_LATCHED && state_next == ST_LATCHED) begin
            status_next[ST_LATCH] = 1'b1;
        end
        if (state_reg == ST_WAIT && state_next == ST_IDLE) begin
            status_next[ST_RECOV] = 1'b1;
        end
        if (state_reg == ST_IDLE && state_next == ST_LATCHED && act == ACT_RETRY) begin
            status_next[ST_EXCEED] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            status_reg <= '0;
            irq_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq_reg <= |(status_next & mask_reg);
        end
    end

    // Bus slave: one wait cycle, then completion; unmapped reads give zero
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wait_reg <= 1'b1;
            readdata_reg <= 32'h0;
        end else begin
            wait_reg <= !((avs_read || avs_write) && wait_reg);
            case (avs_address)
                OFS_CFG: readdata_reg <= cfg_reg;
                OFS_STATUS: readdata_reg <= 32'(status_reg);
                OFS_MASK: readdata_reg <= 32'(mask_reg);
                OFS_CTRL: readdata_reg <= 32'(max_recovery_attempts);
                OFS_STATE: readdata_reg <= {20'h0, attempts_reg, 4'h0, state_reg};
                default: readdata_reg <= 32'h0;
            endcase
        end
    end

    assign avs_readdata = readdata_reg;
    assign avs_waitrequest = wait_reg;
    assign gate_cmd = gate_reg;
    assign fault_pin_n = pin_n_reg;
    assign irq = irq_reg;

    chk_mode_reset_zero: assert property (
        $rose(nrst) |-> mode == 4'h0)
        else $error("mode field not zero after reset");
    chk_latch_hiz_mode: assert property (
        state_reg == ST_IDLE && trip && mode <= 4'h1
        |=> state_reg == ST_LATCHED && gate_cmd.hiz && !fault_pin_n)
        else $error("modes 0/1 did not latch tristated");
    chk_latch_hs_brake: assert property (
        state_reg == ST_IDLE && trip && mode == 4'h2
        |=> state_reg == ST_LATCHED && gate_cmd.hs_on && !gate_cmd.ls_on && !fault_pin_n)
        else $error("mode 2 did not latch in high-side brake");
    chk_latch_ls_brake: assert property (
        state_reg == ST_IDLE && trip && mode == 4'h3
        |=> state_reg == ST_LATCHED && gate_cmd.ls_on && !gate_cmd.hs_on && !fault_pin_n)
        else $error("mode 3 did not latch in low-side brake");
    chk_retry_hiz_flow: assert property (
        state_reg == ST_IDLE && trip && (mode == 4'h4 || mode == 4'h5)
        |=> gate_cmd.hiz && !fault_pin_n
            && state_reg == ($past(exhausted) ? ST_LATCHED : ST_WAIT))
        else $error("modes 4/5 retry or latch wrong");
    chk_retry_hs_exceed: assert property (
        state_reg == ST_IDLE && trip && mode == 4'h6 && exhausted
        |=> state_reg == ST_LATCHED && gate_cmd.hs_on && !fault_pin_n)
        else $error("mode 6 exhaustion not latched in high-side brake");
    chk_retry_ls_exceed: assert property (
        state_reg == ST_IDLE && trip && mode == 4'h7 && exhausted
        |=> state_reg == ST_LATCHED && gate_cmd.ls_on && !fault_pin_n)
        else $error("mode 7 exhaustion not latched in low-side brake");
    chk_report_only_pin: assert property (
        state_reg == ST_IDLE && trip && mode == 4'h8
        |=> !fault_pin_n && gate_cmd == 3'b000 && state_reg == ST_REPORT)
        else $error("report mode changed the gate drive");
    chk_disabled_quiet: assert property (
        state_reg == ST_IDLE && mode >= 4'h9 && mode <= 4'hc |=> fault_pin_n)
        else $error("disabled mode raised a fault");
    chk_undefined_disabled: assert property (
        state_reg == ST_IDLE && mode > 4'hc |=> state_reg == ST_IDLE && fault_pin_n)
        else $error("undefined mode not treated as disabled");
    chk_wait_holds: assert property (
        state_reg == ST_WAIT && retry_cnt_reg != 32'h0
        |=> state_reg == ST_WAIT && !fault_pin_n)
        else $error("recovery wait ended early");

    cov_latched: cover property (state_reg == ST_IDLE ##1 state_reg == ST_LATCHED);
    cov_recovered: cover property (state_reg == ST_WAIT ##1 state_reg == ST_IDLE);
    cov_report: cover property (state_reg == ST_REPORT);
    cov_exceeded: cover property (status_reg[ST_EXCEED]);
endmodule

// file: lclf_pkg.sv
package lclf_pkg;

    // Register byte offsets
    localparam logic [4:0] OFS_CFG = 5'h00;
    localparam logic [4:0] OFS_STATUS = 5'h04;
    localparam logic [4:0] OFS_MASK = 5'h08;
    localparam logic [4:0] OFS_CTRL = 5'h0c;
    localparam logic [4:0] OFS_STATE = 5'h10;

    // Field positions in fault_configuration_one
    localparam int MODE_LSB = 15;
    localparam int DEG_LSB = 11;
    localparam int RETRY_LSB = 7;
    localparam int THR_LSB = 19;
    localparam int FLD_W = 4;

    // Control register fields
    localparam int ATT_LSB = 0;
    localparam int CLR_BIT = 8;

    // Reset values
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [3:0] MASK_RST = 4'h0;
    localparam logic [3:0] ATT_RST = 4'h3;

    // Status bit positions
    localparam int ST_TRIP = 0;
    localparam int ST_LATCH = 1;
    localparam int ST_RECOV = 2;
    localparam int ST_EXCEED = 3;
    localparam int NSTAT = 4;

    // Clock rate and the derived cycles per microsecond
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned CYC_PER_US_DEF = CLK_MHZ;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_LATCHED = 4'b0100,
        ST_REPORT = 4'b1000
    } lclf_state_t;

    typedef enum logic [1:0] {
        ACT_LATCH = 2'h0,
        ACT_RETRY = 2'h1,
        ACT_REPORT = 2'h2,
        ACT_OFF = 2'h3
    } lclf_act_t;

    typedef struct packed {
        logic hiz;
        logic hs_on;
        logic ls_on;
    } lclf_gate_t;

    // Filter time per code, in microseconds; codes 0 and 1 give zero
    function automatic int unsigned deg_time_us(input logic [3:0] c);
        case (c)
            4'h2: deg_time_us = 200;
            4'h3: deg_time_us = 500;
            4'h4: deg_time_us = 1000;
            4'h5: deg_time_us = 2500;
            4'h6: deg_time_us = 5000;
            4'h7: deg_time_us = 7500;
            4'h8: deg_time_us = 10000;
            4'h9: deg_time_us = 25000;
            4'ha: deg_time_us = 50000;
            4'hb: deg_time_us = 75000;
            4'hc: deg_time_us = 100000;
            4'hd: deg_time_us = 200000;
            4'he: deg_time_us = 500000;
            4'hf: deg_time_us = 1000000;
            default: deg_time_us = 0;
        endcase
    endfunction

    // Recovery wait per code, in milliseconds
    function automatic int unsigned retry_time_ms(input logic [3:0] c);
        case (c)
            4'h0: retry_time_ms = 300;
            4'h1: retry_time_ms = 500;
            default: retry_time_ms = (32'(c) - 32'd1) * 32'd1000;
        endcase
    endfunction

    // Current threshold per code, in milliamperes
    function automatic logic [15:0] thr_ma(input logic [3:0] c);
        case (c)
            4'h0: thr_ma = 16'd125;
            4'h1: thr_ma = 16'd250;
            4'h2: thr_ma = 16'd500;
            4'he: thr_ma = 16'd7000;
            4'hf: thr_ma = 16'd8000;
            default: thr_ma = 16'((32'(c) - 32'd1) * 32'd500);
        endcase
    endfunction

endpackage

// file: lclf_deglitch.sv
`timescale 1ns/1ps
module lclf_deglitch import lclf_pkg::*; (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic cond,
    input wire logic [31:0] limit,
    output logic trip
);
    logic [31:0] cnt_reg;
    logic trip_reg;

    // Continuous excursion counter; any drop restarts it
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cnt_reg <= 32'h0;
            trip_reg <= 1'b0;
        end else if (!cond) begin
            cnt_reg <= 32'h0;
            trip_reg <= 1'b0;
        end else if (cnt_reg + 32'h1 >= limit) begin
            trip_reg <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 32'h1;
        end
    end

    assign trip = trip_reg;

    chk_drop_clears_trip: assert property (@(posedge clk_sys) disable iff (!nrst)
        !cond |=> !trip)
        else $error("trip held after condition dropped");
    chk_trip_after_filter: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(trip) |-> $past(cnt_reg) + 32'h1 >= $past(limit))
        else $error("trip rose before filter time");
endmodule

// file: lclf_stage_model.sv
`timescale 1ns/1ps
module lclf_stage_model import lclf_pkg::*; (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire lclf_gate_t gate_cmd,
    input wire logic [15:0] load_ma,
    output logic [15:0] phase_current_ma
);
    // Stalled rotor draws load current only while the bridge switches normally;
    // tristate or either brake starves the winding, so the sensed current falls
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase_current_ma <= 16'h0000;
        end else if (gate_cmd.hiz || gate_cmd.hs_on || gate_cmd.ls_on) begin
            phase_current_ma <= 16'h0000;
        end else begin
            phase_current_ma <= load_ma;
        end
    end
endmodule

// file: lclf_fault_resp_tb.sv
`timescale 1ns/1ps
module lclf_fault_resp_tb import lclf_pkg::*; ;
    logic clk_sys;
    logic nrst;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [15:0] phase_current_ma;
    logic [15:0] load_ma;
    lclf_gate_t gate_cmd;
    logic fault_pin_n;
    logic irq;
    logic [31:0] rd;
    logic [31:0] seed;
    int errors;
    int comparisons;

    // One cycle per microsecond keeps the filter times of codes 2 to 4 short
    lclf_fault_resp #(.CYC_PER_US(1)) i_dut (
        .clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .phase_current_ma(phase_current_ma),
        .gate_cmd(gate_cmd), .fault_pin_n(fault_pin_n), .irq(irq)
    );

    lclf_stage_model i_stage (
        .clk_sys(clk_sys), .nrst(nrst), .gate_cmd(gate_cmd), .load_ma(load_ma),
        .phase_current_ma(phase_current_ma)
    );

    // 250 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Threshold in mA, worked out from the code independently of the design
    function automatic logic [15:0] thr(input logic [3:0] c);
        case (c)
            4'h0: return 16'd125;
            4'h1: return 16'd250;
            4'h2: return 16'd500;
            4'he: return 16'd7000;
            4'hf: return 16'd8000;
            default: return 16'(c - 4'h1) * 16'd500;
        endcase
    endfunction

    // Drive {hiz, hs_on, ls_on} that each response mode applies
    function automatic logic [2:0] exp_gate(input int m);
        case (m)
            0, 1, 4, 5: return 3'b100;
            2, 6: return 3'b010;
            3, 7: return 3'b001;
            default: return 3'b000;
        endcase
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Avalon master: hold everything until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        q = avs_readdata;
        if (n >= 100) begin
            errors++;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        nrst <= 1'b0;
        load_ma <= 16'h0000;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
    endtask

    task automatic wait_fault(input int lim, output int n);
        n = 0;
        while (fault_pin_n !== 1'b0 && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
    endtask

    // Trip one response mode with a one-cycle filter and check the drive
    task automatic run_mode(input int m, input int mx);
        logic [31:0] r;
        logic [3:0] es;
        int n;
        r = rnd();
        do_reset();
        bus(1'b1, OFS_CTRL, 32'(mx), rd);
        bus(1'b1, OFS_CFG, (32'(r[3:0]) << THR_LSB) | (32'(m) << MODE_LSB), rd);
        load_ma <= thr(r[3:0]);
        repeat (20) @(posedge clk_sys);
        chk("pin at threshold", 32'h1, 32'(fault_pin_n));
        load_ma <= thr(r[3:0]) + 16'h0001 + 16'(r[13:8]);
        wait_fault(60, n);
        repeat (3) @(posedge clk_sys);
        es = (m >= 9) ? 4'h1 : (m == 8) ? 4'h8 : (m < 4 || mx == 0) ? 4'h4 : 4'h2;
        chk("fault pin", 32'(m >= 9), 32'(fault_pin_n));
        chk("gate", 32'(exp_gate(m)), 32'(gate_cmd));
        bus(1'b0, OFS_STATE, 32'h0, rd);
        chk("state", 32'(es), 32'(rd[3:0]));
        if (es == 4'h2) begin
            chk("attempts", 32'h1, 32'(rd[11:8]));
        end
        // Sticky events: entered, latched, and exhausted when a retry mode latches at once
        bus(1'b0, OFS_STATUS, 32'h0, rd);
        es = (es == 4'h4) ? ((m < 4) ? 4'h3 : 4'hb) : 4'(es != 4'h1);
        chk("status", 32'(es), 32'(rd[3:0]));
    endtask

    task automatic give_verdict();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Watchdog, well beyond the few thousand cycles the sequence needs
    initial begin
        repeat (40000) @(posedge clk_sys);
        errors++;
        give_verdict();
    end

    initial begin
        int n;
        int dg[3];
        logic [31:0] r;
        dg = '{200, 500, 1000};
        seed = 32'h95a5331b;
        nrst = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        load_ma = 16'h0000;
        errors = 0;
        comparisons = 0;
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        // Reset values, unmapped place and read-back
        bus(1'b0, OFS_CFG, 32'h0, rd);
        chk("cfg reset", 32'h0, rd);
        bus(1'b0, OFS_MASK, 32'h0, rd);
        chk("mask reset", 32'h0, 32'(rd[3:0]));
        bus(1'b0, OFS_CTRL, 32'h0, rd);
        chk("attempt limit reset", 32'h3, 32'(rd[3:0]));
        bus(1'b0, OFS_STATE, 32'h0, rd);
        chk("state reset", 32'h1, 32'(rd[3:0]));
        bus(1'b1, 5'h14, 32'hffff_ffff, rd);
        bus(1'b0, 5'h14, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        r = rnd();
        bus(1'b1, OFS_CFG, r, rd);
        bus(1'b0, OFS_CFG, 32'h0, rd);
        chk("cfg rw", r, rd);
        // Every mode code with retries exhausted at once, then modes 4 to 7 with one retry left
        for (int m = 0; m < 16; m++) begin
            run_mode(m, 0);
        end
        for (int m = 4; m < 8; m++) begin
            run_mode(m, 1);
        end
        // Filter codes 2 to 4; a one-cycle dip at 150 cycles restarts the count
        for (int c = 2; c < 5; c++) begin
            do_reset();
            bus(1'b1, OFS_CFG, (32'(c) << DEG_LSB), rd);
            load_ma <= 16'd1000;
            repeat (150) @(posedge clk_sys);
            load_ma <= 16'h0000;
            @(posedge clk_sys);
            load_ma <= 16'd1000;
            wait_fault(dg[c - 2] + 50, n);
            chk("filter too short", 32'h1, 32'(n >= dg[c - 2]));
            chk("filter too long", 32'h1, 32'(n <= dg[c - 2] + 8));
        end
        // Interrupt: masked, unmasked, cleared by status read; then latch release
        do_reset();
        bus(1'b1, OFS_CFG, (32'h2 << MODE_LSB), rd);
        load_ma <= 16'd1000;
        wait_fault(60, n);
        load_ma <= 16'h0000;
        repeat (20) @(posedge clk_sys);
        chk("irq masked", 32'h0, 32'(irq));
        chk("latched pin", 32'h0, 32'(fault_pin_n));
        bus(1'b1, OFS_MASK, 32'h3, rd);
        repeat (2) @(posedge clk_sys);
        chk("irq unmasked", 32'h1, 32'(irq));
        bus(1'b0, OFS_STATUS, 32'h0, rd);
        chk("status", 32'h3, 32'(rd[3:0]));
        repeat (2) @(posedge clk_sys);
        chk("irq cleared", 32'h0, 32'(irq));
        bus(1'b0, OFS_STATUS, 32'h0, rd);
        chk("status cleared", 32'h0, 32'(rd[3:0]));
        bus(1'b1, OFS_CTRL, 32'h103, rd);
        repeat (3) @(posedge clk_sys);
        chk("pin released", 32'h1, 32'(fault_pin_n));
        chk("gate released", 32'h0, 32'(gate_cmd));
        give_verdict();
    end
endmodule
